// ===== logic/pwr_ack_ctrl.sv
// Power-on acknowledge, boot strap, reset levels, interrupt pin, warm reset
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module pwr_ack_ctrl
   import pwr_ack_pkg::*;
#(
   parameter longint unsigned HOLD_CYC = HOLD_WINDOW_CYC
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic on_req,
   input wire logic hold_on_pin,
   input wire logic boot_strap,
   input wire logic warm_reset_pin_n,
   input wire logic sleep_req,
   input wire logic seq_done,
   input wire logic [7:0] int_src,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   output logic reset_out_n,
   output logic irq_n,
   output logic seq_up,
   output logic seq_act_off,
   output logic seq_slp_off,
   output logic seq_sel,
   output logic [7:0] cfg_area_lo,
   output logic [7:0] cfg_area_hi,
   output logic [7:0] warm_keep,
   output logic [2:0] state
);
   // ====================================================================
   // Pin synchronisers
   logic [1:0] on_s_q, hold_s_q, boot_s_q, warm_s_q, slp_s_q;
   logic hold_d1_q, warm_d1_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         on_s_q <= 2'b00;
         hold_s_q <= 2'b00;
         boot_s_q <= 2'b00;
         warm_s_q <= 2'b11;
         slp_s_q <= 2'b00;
      end else begin
         on_s_q <= {on_s_q[0], on_req};
         hold_s_q <= {hold_s_q[0], hold_on_pin};
         boot_s_q <= {boot_s_q[0], boot_strap};
         warm_s_q <= {warm_s_q[0], warm_reset_pin_n};
         slp_s_q <= {slp_s_q[0], sleep_req};
      end
   end

   // Edge history, read only from second stages
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hold_d1_q <= 1'b0;
         warm_d1_q <= 1'b1;
      end else begin
         hold_d1_q <= hold_s_q[1];
         warm_d1_q <= warm_s_q[1];
      end
   end
   logic hold_fall, warm_fall;
   assign hold_fall = hold_d1_q & ~hold_s_q[1];
   assign warm_fall = warm_d1_q & ~warm_s_q[1];

   // ====================================================================
   // Register bank with reset domains
   pstate_t st_q;
   logic hw_clr, swo_clr;
   logic [7:0] cfg_q, dev_q, int_mask_q, hw_scr_q, swo_scr_q;
   logic [7:0] boot_q, cause_q, pend_q;
   logic keep_set, off_any, off_hw;

   function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
      wr_hit = wr_en && (addr == a);
   endfunction

   // Hard domain: configuration, interrupt mask, scratch
   reg_bank u_cfg (.clk(clk), .nrst(nrst), .clr(hw_clr),
      .wr(wr_hit(REG_CFG)), .wdata(wdata), .rst_val(CFG_RST), .q(cfg_q));
   reg_bank u_imask (.clk(clk), .nrst(nrst), .clr(hw_clr),
      .wr(wr_hit(REG_INT_MASK)), .wdata(wdata), .rst_val(INT_MASK_RST),
      .q(int_mask_q));
   reg_bank u_hscr (.clk(clk), .nrst(nrst), .clr(hw_clr),
      .wr(wr_hit(REG_HW_SCRATCH)), .wdata(wdata), .rst_val(8'h00),
      .q(hw_scr_q));
   // Switch-off domain: cleared by both off resets
   reg_bank u_sscr (.clk(clk), .nrst(nrst), .clr(swo_clr),
      .wr(wr_hit(REG_SWO_SCRATCH)), .wdata(wdata), .rst_val(8'h00),
      .q(swo_scr_q));
   reg_bank u_wkeep (.clk(clk), .nrst(nrst), .clr(swo_clr),
      .wr(wr_hit(REG_WARM_KEEP)), .wdata(wdata), .rst_val(WARM_KEEP_RST),
      .q(warm_keep));

   logic auto_keep_on_mode, keep_autoset, off_hw_cfg, int_slp_mask;
   assign auto_keep_on_mode = cfg_q[CFG_AUTO_KEEP_BIT];
   assign keep_autoset = cfg_q[CFG_KEEP_AUTOSET_BIT];
   assign off_hw_cfg = cfg_q[CFG_OFF_HARD_RESET_LEVEL_BIT];
   assign int_slp_mask = cfg_q[CFG_INT_SLEEP_MASK_BIT];

   logic keep_on_bit;
   assign keep_on_bit = dev_q[DEV_KEEP_ON_BIT];

   // Device control: switch-off domain, autoset wins over a write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dev_q <= 8'h00;
      end else if (keep_set) begin
         dev_q[DEV_KEEP_ON_BIT] <= 1'b1;
      end else if (swo_clr) begin
         dev_q <= 8'h00;
      end else if (wr_hit(REG_DEVICE_CONTROL_REG)) begin
         dev_q <= wdata;
      end
   end

   // Power-on domain: switch-off cause survives off resets
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cause_q <= 8'h00;
      end else if (off_any) begin
         cause_q <= cause_q | off_cause() | (off_hw ? CAUSE_HARD_RESET_LEVEL : 8'h00);
      end else if (wr_hit(REG_SWOFF_CAUSE)) begin
         cause_q <= cause_q & ~wdata;
      end
   end

   // Interrupt pending bits: hard domain, source set wins over clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend_q <= 8'h00;
      end else if (hw_clr) begin
         pend_q <= 8'h00;
      end else begin
         pend_q <= (pend_q & ~(wr_hit(REG_INT_PEND) ? wdata : 8'h00))
            | int_src;
      end
   end

   // ====================================================================
   // Keep-alive window timer
   logic [TMR_W-1:0] tmr_q;
   logic tmr_exp;
   localparam logic [TMR_W-1:0] HOLD_LAST = TMR_W'(HOLD_CYC - 1);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tmr_q <= '0;
      end else if (st_q != ST_ACTIVE && st_q != ST_SLEEP) begin
         tmr_q <= '0;
      end else if (tmr_q != HOLD_LAST) begin
         tmr_q <= tmr_q + 1'b1;
      end
   end
   assign tmr_exp = (tmr_q == HOLD_LAST - 1'b1);

   // Off request sources per acknowledge mode
   logic keep_ctl, ack_level, off_pin, off_keep, off_tmr;
   assign keep_ctl = auto_keep_on_mode;
   assign ack_level = keep_ctl ? keep_on_bit : hold_s_q[1];
   assign off_pin = !keep_ctl && hold_fall;
   assign off_keep = keep_ctl && dev_q[DEV_KEEP_ON_BIT] == 1'b0
      && (keep_autoset ? 1'b1 : tmr_q == HOLD_LAST);
   assign off_tmr = !(keep_ctl && keep_autoset) && tmr_exp && !ack_level;

   function automatic logic [7:0] off_cause();
      off_cause = (off_pin ? CAUSE_PIN : 8'h00)
         | (off_keep ? CAUSE_KEEP : 8'h00)
         | (off_tmr ? CAUSE_TIMER : 8'h00);
   endfunction

   logic live;
   assign live = (st_q == ST_ACTIVE) || (st_q == ST_SLEEP);
   assign off_any = live && (off_pin || off_keep || off_tmr);
   assign off_hw = off_hw_cfg;
   assign hw_clr = off_any && off_hw;
   assign swo_clr = off_any;

   // ====================================================================
   // Power state machine
   logic from_sleep_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_OFF;
         from_sleep_q <= 1'b0;
      end else begin
         unique case (st_q)
            ST_OFF: begin
               if (on_s_q[1]) begin
                  st_q <= ST_UP;
               end
            end
            ST_UP, ST_WARM: begin
               if (seq_done) begin
                  st_q <= ST_ACTIVE;
               end
            end
            ST_ACTIVE, ST_SLEEP: begin
               if (off_any) begin
                  from_sleep_q <= (st_q == ST_SLEEP);
                  st_q <= ST_DOWN;
               end else if (warm_fall) begin
                  st_q <= ST_WARM;
               end else begin
                  st_q <= slp_s_q[1] ? ST_SLEEP : ST_ACTIVE;
               end
            end
            ST_DOWN: begin
               if (seq_done) begin
                  st_q <= ST_OFF;
               end
            end
            default: st_q <= ST_OFF;
         endcase
      end
   end
   assign keep_set = st_q == ST_UP && seq_done && auto_keep_on_mode
      && keep_autoset;

   // Strap latched when power-up finishes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         boot_q <= 8'h00;
      end else if (st_q == ST_UP && seq_done) begin
         boot_q <= {7'h00, boot_s_q[1]};
      end
   end

   // ====================================================================
   // Sequence strobes and outputs
   assign seq_up = (st_q == ST_UP) || (st_q == ST_WARM);
   assign seq_act_off = (st_q == ST_DOWN) && !from_sleep_q;
   assign seq_slp_off = (st_q == ST_DOWN) && from_sleep_q;
   // Live strap lets a running sequence branch without editing it
   assign seq_sel = boot_s_q[1];
   assign cfg_area_lo = boot_s_q[1] ? AREA1_LO : AREA0_LO;
   assign cfg_area_hi = boot_s_q[1] ? AREA1_HI : AREA0_HI;
   assign state = st_q;

   // Reset out registered; a warm reset re-asserts it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reset_out_n <= 1'b0;
      end else begin
         reset_out_n <= (st_q == ST_ACTIVE) || (st_q == ST_SLEEP);
      end
   end

   // Interrupt pin, push-pull active low, optionally quiet in sleep
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= !(|(pend_q & ~int_mask_q)
            && !(st_q == ST_SLEEP && int_slp_mask));
      end
   end

   // Read data one cycle after the strobe, zero for unmapped
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd_en) begin
         unique case (addr)
            REG_DEVICE_CONTROL_REG: rdata <= dev_q;
            REG_CFG: rdata <= cfg_q;
            REG_STATUS: rdata <= {5'h00, st_q};
            REG_BOOT_STATUS: rdata <= boot_q;
            REG_SWOFF_CAUSE: rdata <= cause_q;
            REG_HW_SCRATCH: rdata <= hw_scr_q;
            REG_SWO_SCRATCH: rdata <= swo_scr_q;
            REG_INT_PEND: rdata <= pend_q;
            REG_INT_MASK: rdata <= int_mask_q;
            REG_WARM_KEEP: rdata <= warm_keep;
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ====================================================================
   // Checks
   rst_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == ST_UP) |=> !reset_out_n)
      else $error("reset released during power-up");
   up_release_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == ST_UP && seq_done) |=> ##1 reset_out_n)
      else $error("reset not released after power-up");
   hold_fall_a: assert property (@(posedge clk) disable iff (!nrst)
      (live && !keep_ctl && hold_fall) |=> st_q == ST_DOWN)
      else $error("hold pin fall not honoured");
   auto_set_a: assert property (@(posedge clk) disable iff (!nrst)
      keep_set |=> keep_on_bit && st_q == ST_ACTIVE)
      else $error("keep-on bit not set");
   boot_lat_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == ST_UP && seq_done) |=> boot_q[0] == $past(boot_s_q[1]))
      else $error("strap not latched");
   cause_keep_a: assert property (@(posedge clk) disable iff (!nrst)
      off_any |=> (cause_q & $past(cause_q)) == $past(cause_q))
      else $error("cause lost on off reset");
   hw_clr_a: assert property (@(posedge clk) disable iff (!nrst)
      hw_clr |=> cfg_q == CFG_RST && int_mask_q == INT_MASK_RST)
      else $error("hard domain not reset");
   swo_only_a: assert property (@(posedge clk) disable iff (!nrst)
      (swo_clr && !hw_clr && !wr_en) |=> $stable(cfg_q) && swo_scr_q == 0)
      else $error("switch-off reset scope wrong");
   down_seq_a: assert property (@(posedge clk) disable iff (!nrst)
      (off_any && st_q == ST_SLEEP) |=> seq_slp_off && !seq_act_off)
      else $error("wrong off sequence");
   warm_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == ST_ACTIVE && warm_fall && !off_any) |=> seq_up)
      else $error("warm reset did not start power-up");
   once_a: assert property (@(posedge clk) disable iff (!nrst)
      off_any |=> !off_any)
      else $error("off request taken twice");
endmodule

// ===== logic/pwr_ack_pkg.sv
// Package of constants and types for the power-on acknowledge control block
package pwr_ack_pkg;
   // ====================================================================
   // Clock and timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned HOLD_WINDOW_S = 8;
   localparam longint unsigned HOLD_WINDOW_CYC =
      longint'(HOLD_WINDOW_S) * longint'(CLK_HZ);
   localparam int TMR_W = 28;

   // ====================================================================
   // Register offsets (plain port, word addresses)
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_DEVICE_CONTROL_REG = 4'h0;
   localparam logic [3:0] REG_CFG = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_BOOT_STATUS = 4'h3;
   localparam logic [3:0] REG_SWOFF_CAUSE = 4'h4;
   localparam logic [3:0] REG_HW_SCRATCH = 4'h5;
   localparam logic [3:0] REG_SWO_SCRATCH = 4'h6;
   localparam logic [3:0] REG_INT_PEND = 4'h7;
   localparam logic [3:0] REG_INT_MASK = 4'h8;
   localparam logic [3:0] REG_WARM_KEEP = 4'h9;

   // Field positions
   localparam int DEV_KEEP_ON_BIT = 0;
   localparam int CFG_AUTO_KEEP_BIT = 0;
   localparam int CFG_KEEP_AUTOSET_BIT = 1;
   localparam int CFG_OFF_HARD_RESET_LEVEL_BIT = 2;
   localparam int CFG_INT_SLEEP_MASK_BIT = 3;

   // Reset values
   localparam logic [7:0] CFG_RST = 8'h0a;
   localparam logic [7:0] INT_MASK_RST = 8'hff;
   localparam logic [7:0] WARM_KEEP_RST = 8'h00;

   // Switch-off cause codes
   localparam logic [7:0] CAUSE_PIN = 8'h01;
   localparam logic [7:0] CAUSE_KEEP = 8'h02;
   localparam logic [7:0] CAUSE_TIMER = 8'h04;
   localparam logic [7:0] CAUSE_HARD_RESET_LEVEL = 8'h80;

   // Configuration area bounds per strap level
   localparam logic [7:0] AREA0_LO = 8'h00;
   localparam logic [7:0] AREA0_HI = 8'h2f;
   localparam logic [7:0] AREA1_LO = 8'h30;
   localparam logic [7:0] AREA1_HI = 8'h5f;

   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_UP = 3'b001,
      ST_ACTIVE = 3'b010,
      ST_SLEEP = 3'b011,
      ST_DOWN = 3'b100,
      ST_WARM = 3'b101
   } pstate_t;
endpackage

// ===== logic/reg_bank.sv
// Small register bank with a clear for its reset domain
`timescale 1ns/10ps
module reg_bank
   import pwr_ack_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic wr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rst_val,
   output logic [7:0] q
);
   logic init_q;

   // ====================================================================
   // Storage, domain clear wins over a write. The async branch loads
   // constants only, so the per-instance default lands on the first clock
   // after power-on reset, below a write made at that same edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q <= 8'h00;
         init_q <= 1'b0;
      end else begin
         init_q <= 1'b1;
         if (clr) begin
            q <= rst_val;
         end else if (wr) begin
            q <= wdata;
         end else if (!init_q) begin
            q <= rst_val;
         end
      end
   end
endmodule

// ===== dv/host_model.sv
// Host processor model that acknowledges power-on through the hold pin
`timescale 1ns/10ps
module host_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic reset_out_n,
   input wire logic ack_en,
   input wire logic [7:0] ack_dly,
   input wire logic drop,
   output logic hold_on_pin
);
   logic [7:0] cnt_q;

   // ==================================================================
   // Acknowledge
   // Pin rises ack_dly + 1 cycles after reset release; a slow host risks the
   // window, so the bench keeps ack_dly well inside it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 8'h00;
         hold_on_pin <= 1'b0;
      end else if (!reset_out_n || drop) begin
         cnt_q <= 8'h00;
         hold_on_pin <= 1'b0;
      end else if (ack_en && cnt_q == ack_dly) begin
         hold_on_pin <= 1'b1;
      end else if (cnt_q != 8'hff) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule

// ===== dv/tb_pwr_ack_ctrl.sv
// Self-checking bench for the power-on acknowledge control block
`timescale 1ns/10ps
module tb_pwr_ack_ctrl
   import pwr_ack_pkg::*;
();
   localparam longint unsigned HC = 40;
   logic clk, nrst, on_req, boot_strap, warm_reset_pin_n, sleep_req;
   logic seq_done, wr_en, rd_en, reset_out_n, irq_n, seq_up, seq_act_off;
   logic seq_slp_off, seq_sel, hold_on_pin, ack_en, drop;
   logic [7:0] int_src, wdata, rdata, cfg_area_lo, cfg_area_hi, warm_keep;
   logic [7:0] ack_dly, hw_v, so_v, wk;
   logic [3:0] addr, seq_cnt;
   logic [2:0] state, prev_st;
   int n_errors = 0;
   int comparisons = 0;
   int n_down = 0;
   int d0, ki;

   pwr_ack_ctrl #(.HOLD_CYC(HC)) pwr_ack_ctrl_i (.clk(clk), .nrst(nrst),
      .on_req(on_req), .hold_on_pin(hold_on_pin), .boot_strap(boot_strap),
      .warm_reset_pin_n(warm_reset_pin_n), .sleep_req(sleep_req),
      .seq_done(seq_done), .int_src(int_src), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .reset_out_n(reset_out_n), .irq_n(irq_n), .seq_up(seq_up),
      .seq_act_off(seq_act_off), .seq_slp_off(seq_slp_off),
      .seq_sel(seq_sel), .cfg_area_lo(cfg_area_lo),
      .cfg_area_hi(cfg_area_hi), .warm_keep(warm_keep), .state(state));

   host_model host_model_i (.clk(clk), .nrst(nrst),
      .reset_out_n(reset_out_n), .ack_en(ack_en), .ack_dly(ack_dly),
      .drop(drop), .hold_on_pin(hold_on_pin));

   // ==================================================================
   // Clock, sequencer responder and monitor
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Finish any running sequence after a random number of cycles
   always @(posedge clk) begin
      seq_done <= 1'b0;
      if ((seq_up || seq_act_off || seq_slp_off) && !seq_done) begin
         if (seq_cnt == 4'h0) begin
            seq_done <= 1'b1;
            seq_cnt <= 4'($urandom_range(2, 9));
         end else begin
            seq_cnt <= seq_cnt - 4'h1;
         end
      end
   end

   // Reset output must stay low for the whole power-up; count shutdowns
   always @(negedge clk) begin
      if (state === ST_UP) begin
         check_b("reset_out_n", reset_out_n, 1'b0);
      end
      if (state === ST_DOWN && prev_st !== ST_DOWN) begin
         n_down++;
      end
      prev_st = state;
   end

   // ==================================================================
   // Tasks
   task automatic check(input string what, input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic check_b(input string what, input logic seen, exp);
      check(what, {7'h00, seen}, {7'h00, exp});
   endtask

   task automatic give_verdict;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [3:0] a,
                         input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      check(what, rdata, exp);
   endtask

   // Bounded wait for a state, then compare it
   task automatic wait_st(input logic [2:0] s, input int lim);
      int i;
      i = 0;
      while (state !== s && i < lim) begin
         @(negedge clk);
         i++;
      end
      check("state", {5'h00, state}, {5'h00, s});
   endtask

   task automatic power_up(input logic s);
      @(posedge clk) boot_strap <= s;
      repeat (4) @(posedge clk);
      on_req <= 1'b1;
      wait_st(ST_UP, 10);
      @(posedge clk) on_req <= 1'b0;
      check_b("seq_sel", seq_sel, s);
      check("area_lo", cfg_area_lo, s ? AREA1_LO : AREA0_LO);
      check("area_hi", cfg_area_hi, s ? AREA1_HI : AREA0_HI);
      wait_st(ST_ACTIVE, 20);
      @(posedge clk) boot_strap <= ~s;
      repeat (3) @(negedge clk);
      check_b("reset_out_n", reset_out_n, 1'b1);
      rd_chk("boot", REG_BOOT_STATUS, {7'h00, s});
   endtask

   task automatic off_done(input logic [7:0] cause);
      wait_st(ST_OFF, 20);
      check("downs", 8'(n_down - d0), 8'h01);
      rd_chk("cause", REG_SWOFF_CAUSE, cause);
      wr(REG_SWOFF_CAUSE, 8'hff);
   endtask

   // Cut a hang short
   initial begin
      repeat (8000) @(posedge clk);
      n_errors++;
      give_verdict;
   end

   // ==================================================================
   // Main sequence
   initial begin
      nrst = 1'b0;
      {on_req, boot_strap, sleep_req, seq_done, wr_en, rd_en} = 6'h00;
      {ack_en, drop, prev_st} = 5'h00;
      warm_reset_pin_n = 1'b1;
      {int_src, wdata, addr} = 20'h00000;
      seq_cnt = 4'h3;
      ack_dly = 8'h05;
      void'($urandom(18908));
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      check_b("reset_out_n", reset_out_n, 1'b0);
      check_b("irq_n", irq_n, 1'b1);
      rd_chk("cfg", REG_CFG, CFG_RST);
      rd_chk("mask", REG_INT_MASK, INT_MASK_RST);
      rd_chk("unmapped", 4'hf, 8'h00);
      hw_v = 8'($urandom_range(1, 255));
      so_v = 8'($urandom_range(1, 255));
      wk = 8'($urandom_range(1, 255));
      wr(REG_HW_SCRATCH, hw_v);
      wr(REG_SWO_SCRATCH, so_v);
      wr(REG_WARM_KEEP, wk);
      // Pin mode, acknowledged host, interrupts, off from sleep
      ack_dly <= 8'($urandom_range(1, 20));
      ack_en <= 1'b1;
      power_up(1'($urandom));
      repeat (2 * HC) @(negedge clk);
      wait_st(ST_ACTIVE, 0);
      ki = $urandom_range(0, 7);
      @(posedge clk) int_src <= 8'(8'h01 << ki);
      @(posedge clk) int_src <= 8'h00;
      repeat (3) @(negedge clk);
      check_b("irq_n", irq_n, 1'b1);
      wr(REG_INT_MASK, 8'(~(8'h01 << ki)));
      repeat (3) @(negedge clk);
      check_b("irq_n", irq_n, 1'b0);
      wr(REG_INT_MASK, 8'h00);
      @(posedge clk) sleep_req <= 1'b1;
      wait_st(ST_SLEEP, 10);
      // Pin is registered, so give it one edge with SLEEP in place
      @(negedge clk);
      check_b("irq_n", irq_n, 1'b1);
      wr(REG_CFG, 8'h02);
      repeat (3) @(negedge clk);
      check_b("irq_n", irq_n, 1'b0);
      d0 = n_down;
      @(posedge clk) drop <= 1'b1;
      wait_st(ST_DOWN, 10);
      check_b("slp_off", seq_slp_off, 1'b1);
      off_done(CAUSE_PIN);
      @(posedge clk) {drop, sleep_req} <= 2'b00;
      rd_chk("hw", REG_HW_SCRATCH, hw_v);
      rd_chk("swo", REG_SWO_SCRATCH, 8'h00);
      check("warm_keep", warm_keep, 8'h00);
      rd_chk("cfg", REG_CFG, 8'h02);
      rd_chk("pend", REG_INT_PEND, 8'(8'h01 << ki));
      wr(REG_INT_PEND, 8'hff);
      // No acknowledge: window expiry with hard reset selected
      wr(REG_CFG, 8'h04);
      wr(REG_SWO_SCRATCH, so_v);
      ack_en <= 1'b0;
      d0 = n_down;
      power_up(1'($urandom));
      repeat (HC - 12) @(negedge clk);
      wait_st(ST_ACTIVE, 0);
      wait_st(ST_DOWN, 12);
      check_b("act_off", seq_act_off, 1'b1);
      off_done(CAUSE_TIMER | CAUSE_HARD_RESET_LEVEL);
      rd_chk("hw", REG_HW_SCRATCH, 8'h00);
      rd_chk("swo", REG_SWO_SCRATCH, 8'h00);
      rd_chk("cfg", REG_CFG, CFG_RST);
      rd_chk("mask", REG_INT_MASK, INT_MASK_RST);
      // Auto keep-on mode with autoset
      wr(REG_CFG, 8'h03);
      d0 = n_down;
      power_up(1'($urandom));
      rd_chk("dev", REG_DEVICE_CONTROL_REG, 8'h01);
      repeat (2 * HC) @(negedge clk);
      wait_st(ST_ACTIVE, 0);
      wr(REG_DEVICE_CONTROL_REG, 8'h00);
      wait_st(ST_DOWN, 8);
      off_done(CAUSE_KEEP);
      rd_chk("dev", REG_DEVICE_CONTROL_REG, 8'h00);
      // Keep bit without autoset, held by the host, then warm reset
      wr(REG_CFG, 8'h01);
      wr(REG_HW_SCRATCH, hw_v);
      wr(REG_WARM_KEEP, wk);
      power_up(1'($urandom));
      rd_chk("dev", REG_DEVICE_CONTROL_REG, 8'h00);
      wr(REG_DEVICE_CONTROL_REG, 8'h01);
      repeat (2 * HC) @(negedge clk);
      wait_st(ST_ACTIVE, 0);
      @(posedge clk) warm_reset_pin_n <= 1'b0;
      wait_st(ST_WARM, 8);
      check_b("seq_up", seq_up, 1'b1);
      @(posedge clk) warm_reset_pin_n <= 1'b1;
      wait_st(ST_ACTIVE, 20);
      check("warm_keep", warm_keep, wk);
      rd_chk("hw", REG_HW_SCRATCH, hw_v);
      rd_chk("status", REG_STATUS, 8'(ST_ACTIVE));
      give_verdict;
   end
endmodule
